/* rtl/mie_pkg.sv */
// Purpose: constants, opcodes and carrier types
// Assumes: 16-bit instruction words, 10-bit program counter
// Notes: opcode numbering is local
package mie_pkg;
    localparam int PC_W = 10;
    localparam int STACK_DEPTH = 8;
    localparam logic [9:0] PC_RESET = 10'h000;
    localparam logic [9:0] INT_VECTOR = 10'h008;
    localparam logic [7:0] ACCUM_RESET = 8'h00;
    localparam logic [3:0] IO_PAGE_MIN = 4'h5;
    localparam logic [3:0] NIBBLE_MAX = 4'h9;
    localparam logic [7:0] BCD_MAX = 8'h99;
    localparam logic [8:0] BCD_LOW_FIX = 9'h006;
    localparam logic [8:0] BCD_HIGH_FIX = 9'h060;
    localparam int OP_LSB = 10;
    localparam int DEST_POS = 9;
    localparam int BIT_LSB = 6;
    localparam int PAGE_LSB = 4;
    localparam logic [1:0] PAGE_IO = 2'h0;
    localparam logic [1:0] PAGE_SPECIAL = 2'h1;
    localparam logic [1:0] PAGE_TIMER = 2'h2;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_ACCUM = 12'h008;
    localparam int CTRL_RUN_POS = 0;
    localparam logic CTRL_RUN_RESET = 1'b1;
    localparam logic [15:0] INSTR_IDLE = 16'h0000;

    typedef enum logic [5:0] {
        OP_NOP, OP_AND_REG, OP_OR_REG, OP_XOR_REG, OP_AND_IMM, OP_OR_IMM, OP_XOR_IMM,
        OP_ROT_RIGHT, OP_ROT_LEFT, OP_BIT_SET, OP_BIT_CLEAR, OP_INC, OP_DEC, OP_COMPLEMENT,
        OP_ADD_REG, OP_SUB_REG, OP_ADD_CARRY_REG, OP_REG_SUBTRACT_BORROW, OP_ADD_IMM,
        OP_SUB_IMM, OP_ADD_CARRY_IMM, OP_IMM_SUBTRACT_BORROW, OP_DECIMAL_ADJUST, OP_COMPARE,
        OP_CLEAR_ACCUM, OP_CLEAR_REG, OP_TEST_SKIP_IF_CLEAR, OP_TEST_SKIP_IF_SET,
        OP_INCREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO, OP_STORE_ACCUM, OP_MOVE_REG,
        OP_LOAD_IMMEDIATE, OP_SWAP_NIBBLES, OP_IO_PAGE_STORE, OP_IO_PAGE_LOAD,
        OP_SPECIAL_PAGE_STORE, OP_SPECIAL_PAGE_LOAD, OP_TIMER_MODE_STORE, OP_TIMER_MODE_LOAD,
        OP_TABLE_READ, OP_SLEEP, OP_WATCHDOG_CLEAR, OP_IRQ_ENABLE, OP_IRQ_DISABLE,
        OP_SOFT_INTERRUPT, OP_SUBROUTINE_RETURN, OP_RETURN_IRQ_ENABLE,
        OP_RETURN_WITH_LITERAL, OP_INDEXED_CALL, OP_INDEXED_JUMP, OP_CALL, OP_JUMP,
        OP_LONG_CALL, OP_LONG_JUMP
    } mie_op_type;

    typedef enum logic [1:0] {
        ST_FLUSH = 2'b00,
        ST_EXEC = 2'b01,
        ST_HALT = 2'b11,
        ST_WAIT = 2'b10
    } mie_state_type;

    typedef struct packed {
        logic we;
        logic [5:0] addr;
        logic [7:0] data;
    } mie_file_wr_type;

    typedef struct packed {
        logic we;
        logic [1:0] page;
        logic [3:0] addr;
        logic [7:0] data;
    } mie_page_wr_type;

    typedef struct packed {
        logic c;
        logic hc;
        logic [7:0] sum;
    } mie_alu_type;

    function automatic mie_alu_type mie_add(input logic [7:0] a, input logic [7:0] b,
                                             input logic cin);
        logic [4:0] low;
        logic [8:0] full;
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        mie_add.sum = full[7:0];
        mie_add.c = full[8];
        mie_add.hc = low[4];
    endfunction
endpackage

/* rtl/mie_core.sv */
// Purpose: decode and execute unit of a small 8-bit controller core
// Assumes: program word arrives combinationally on i_pm_data;
//          file and page reads are combinational
// Notes: writes leave a cycle late and are forwarded
// Notes on behaviour
// - 55 distinct instructions.
// - skip next if chosen bit clear, no flags.
// - skip next if chosen bit set, no flags.
// - increment, write dest, skip on zero, no flags.
// - decrement, write dest, skip on zero, no flags.
// - reg + ~accumulator + carry to dest; Z, half-carry, C.
// - imm + ~accumulator + carry to accumulator; Z, half-carry, C.
// - decimal adjust to packed BCD, only carry.
// - io store: accumulator to io register, no flags.
// - io load: io register to accumulator, no flags.
// - special store: accumulator to register, no flags.
// - special load: register to accumulator, no flags.
// - indexed call pushes return, jumps by accumulator, 2 cycles.
// - indexed jump by accumulator, 2 cycles.
// - return pops saved address, 2 cycles.
// - literal return: immediate to accumulator, 2 cycles.
// - load immediate to accumulator, no flags.
// - watchdog clear restarts watchdog, updates both status flags.
// - sleep: timeout 1, powerdown 0; clear: both 1.
// - dest bit 0 to accumulator, 1 to file register.
// - carry = add carry or subtract no-borrow.
// - file operands span 0x00 to 0x3F.
// - io operands span 0x5 to 0xF.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module mie_core
    import mie_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [11:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [PC_W-1:0] o_pm_addr,
    input wire logic [15:0] i_pm_data,
    output logic [5:0] o_file_raddr,
    input wire logic [7:0] i_file_rdata,
    output mie_file_wr_type o_file_wr,
    output logic [1:0] o_page_rsel,
    output logic [3:0] o_page_raddr,
    input wire logic [7:0] i_page_rdata,
    output mie_page_wr_type o_page_wr,
    output logic o_wdt_clear,
    output logic o_sleep_req,
    input wire logic i_wake,
    input wire logic i_wdt_timeout,
    output logic o_timeout_flag,
    output logic o_powerdown_flag,
    output logic o_irq_enable
);
    mie_state_type state_r;
    mie_state_type state_nxt;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic [15:0] ir_r;
    logic [15:0] ir_nxt;
    logic [7:0] accum_r;
    logic c_r;
    logic hc_r;
    logic z_r;
    logic timeout_r;
    logic powerdown_r;
    logic irq_en_r;
    logic run_r;
    logic [PC_W-1:0] stack_r [STACK_DEPTH];
    logic [2:0] stk_idx_r;
    mie_file_wr_type file_wr_r;
    mie_page_wr_type page_wr_r;
    logic wdt_clear_r;
    logic sleep_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [7:0] res;
    logic [PC_W-1:0] target;

    // field decode
    wire mie_op_type op = mie_op_type'(ir_r[15:OP_LSB]);
    wire dest_file = ir_r[DEST_POS];
    wire [2:0] bit_sel = ir_r[8:BIT_LSB];
    wire [5:0] file_addr = ir_r[5:0];
    wire [7:0] imm = ir_r[7:0];
    wire [1:0] page_sel = ir_r[5:PAGE_LSB];
    wire [3:0] page_addr = ir_r[3:0];
    wire [7:0] bit_mask = 8'h01 << bit_sel;
    wire exec = run_r && (state_r == ST_EXEC);

    // forward a write in flight so back-to-back use sees it
    wire file_fwd = file_wr_r.we && (file_wr_r.addr == file_addr);
    wire [7:0] file_val = file_fwd ? file_wr_r.data : i_file_rdata;
    wire page_fwd = page_wr_r.we && (page_wr_r.page == page_sel) && (page_wr_r.addr == page_addr);
    wire [7:0] page_val = page_fwd ? page_wr_r.data : i_page_rdata;

    // instruction classes
    wire is_imm = op inside {OP_AND_IMM, OP_OR_IMM, OP_XOR_IMM, OP_ADD_IMM, OP_SUB_IMM,
                             OP_ADD_CARRY_IMM, OP_IMM_SUBTRACT_BORROW};
    wire is_sub = op inside {OP_SUB_REG, OP_REG_SUBTRACT_BORROW, OP_SUB_IMM,
                             OP_IMM_SUBTRACT_BORROW, OP_COMPARE};
    wire use_carry = op inside {OP_ADD_CARRY_REG, OP_REG_SUBTRACT_BORROW, OP_ADD_CARRY_IMM,
                                OP_IMM_SUBTRACT_BORROW};
    wire is_arith = op inside {OP_ADD_REG, OP_SUB_REG, OP_ADD_CARRY_REG,
                               OP_REG_SUBTRACT_BORROW, OP_ADD_IMM, OP_SUB_IMM,
                               OP_ADD_CARRY_IMM, OP_IMM_SUBTRACT_BORROW};
    wire dest_op = op inside {OP_AND_REG, OP_OR_REG, OP_XOR_REG, OP_ROT_RIGHT, OP_ROT_LEFT,
                              OP_INC, OP_DEC, OP_COMPLEMENT, OP_ADD_REG, OP_SUB_REG,
                              OP_ADD_CARRY_REG, OP_REG_SUBTRACT_BORROW,
                              OP_INCREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO,
                              OP_MOVE_REG, OP_SWAP_NIBBLES};
    wire file_only = op inside {OP_STORE_ACCUM, OP_BIT_SET, OP_BIT_CLEAR, OP_CLEAR_REG};
    wire accum_only = is_imm || (op inside {OP_DECIMAL_ADJUST, OP_CLEAR_ACCUM,
                              OP_LOAD_IMMEDIATE, OP_RETURN_WITH_LITERAL, OP_IO_PAGE_LOAD,
                              OP_SPECIAL_PAGE_LOAD, OP_TIMER_MODE_LOAD});
    wire upd_z = is_arith || (op inside {OP_AND_REG, OP_OR_REG, OP_XOR_REG, OP_AND_IMM,
                              OP_OR_IMM, OP_XOR_IMM, OP_INC, OP_DEC, OP_COMPLEMENT,
                              OP_COMPARE, OP_CLEAR_ACCUM, OP_CLEAR_REG, OP_MOVE_REG});
    wire upd_c = is_arith || (op inside {OP_COMPARE, OP_ROT_RIGHT, OP_ROT_LEFT});
    wire is_call = op inside {OP_INDEXED_CALL, OP_CALL, OP_LONG_CALL};
    wire is_ret = op inside {OP_SUBROUTINE_RETURN, OP_RETURN_IRQ_ENABLE,
                             OP_RETURN_WITH_LITERAL};
    wire is_jump = is_call || is_ret || (op inside {OP_INDEXED_JUMP, OP_JUMP, OP_LONG_JUMP});

    // one adder; subtract adds ~accumulator
    wire [7:0] opnd = is_imm ? imm : file_val;
    wire [7:0] add_b = is_sub ? ~accum_r : accum_r;
    wire add_cin = use_carry ? c_r : is_sub;
    wire mie_alu_type sum = mie_add(opnd, add_b, add_cin);

    // BCD correction
    wire bcd_low = hc_r || (accum_r[3:0] > NIBBLE_MAX);
    wire bcd_high = c_r || (accum_r > BCD_MAX);
    wire [8:0] bcd_step = {1'b0, accum_r} + (bcd_low ? BCD_LOW_FIX : 9'h000);
    wire [8:0] bcd_val = bcd_step + (bcd_high ? BCD_HIGH_FIX : 9'h000);
    wire bcd_carry = bcd_high || bcd_step[8] || bcd_val[8];

    // io page answers from its floor up
    wire io_ok = page_addr >= IO_PAGE_MIN;
    wire page_store = op inside {OP_IO_PAGE_STORE, OP_SPECIAL_PAGE_STORE, OP_TIMER_MODE_STORE};
    wire store_ok = (op != OP_IO_PAGE_STORE) || io_ok;

    // d-bit routing
    wire wr_file = exec && ((dest_op && dest_file) || file_only);
    wire wr_accum = exec && ((dest_op && !dest_file) || accum_only);

    // skips never touch flags
    wire skip = (op == OP_TEST_SKIP_IF_CLEAR) ? !file_val[bit_sel] :
                (op == OP_TEST_SKIP_IF_SET) ? file_val[bit_sel] :
                (op inside {OP_INCREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO}) ?
                (res == 8'h00) : 1'b0;

    wire [2:0] stk_top = stk_idx_r - 3'h1;

    always_comb
    begin
        res = accum_r;
        case (op)
            OP_AND_REG, OP_AND_IMM: res = accum_r & opnd;
            OP_OR_REG, OP_OR_IMM: res = accum_r | opnd;
            OP_XOR_REG, OP_XOR_IMM: res = accum_r ^ opnd;
            OP_ROT_RIGHT: res = {c_r, file_val[7:1]};
            OP_ROT_LEFT: res = {file_val[6:0], c_r};
            OP_BIT_SET: res = file_val | bit_mask;
            OP_BIT_CLEAR: res = file_val & ~bit_mask;
            OP_INC, OP_INCREMENT_SKIP_ZERO: res = file_val + 8'h01;
            OP_DEC, OP_DECREMENT_SKIP_ZERO: res = file_val - 8'h01;
            OP_COMPLEMENT: res = ~file_val;
            OP_ADD_REG, OP_SUB_REG, OP_ADD_CARRY_REG, OP_REG_SUBTRACT_BORROW: res = sum.sum;
            OP_ADD_IMM, OP_SUB_IMM, OP_ADD_CARRY_IMM, OP_IMM_SUBTRACT_BORROW: res = sum.sum;
            OP_COMPARE: res = sum.sum;
            OP_DECIMAL_ADJUST: res = bcd_val[7:0];
            OP_CLEAR_ACCUM, OP_CLEAR_REG: res = 8'h00;
            OP_STORE_ACCUM: res = accum_r;
            OP_MOVE_REG: res = file_val;
            OP_SWAP_NIBBLES: res = {file_val[3:0], file_val[7:4]};
            OP_LOAD_IMMEDIATE, OP_RETURN_WITH_LITERAL: res = imm;
            OP_IO_PAGE_LOAD: res = io_ok ? page_val : 8'h00;
            OP_SPECIAL_PAGE_LOAD, OP_TIMER_MODE_LOAD: res = page_val;
            default: res = accum_r;
        endcase
    end

    always_comb
    begin
        target = pc_r;
        case (op)
            OP_INDEXED_CALL, OP_INDEXED_JUMP: target = {pc_r[9:8], accum_r};
            OP_CALL, OP_JUMP, OP_LONG_CALL, OP_LONG_JUMP: target = ir_r[9:0];
            OP_SUBROUTINE_RETURN, OP_RETURN_IRQ_ENABLE: target = stack_r[stk_top];
            OP_RETURN_WITH_LITERAL: target = stack_r[stk_top];
            default: target = pc_r;
        endcase
    end

    // each taken branch, skip or vector leaves a flush cycle
    always_comb
    begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        ir_nxt = ir_r;
        if (run_r)
        begin
            case (state_r)
                ST_EXEC:
                begin
                    ir_nxt = i_pm_data;
                    pc_nxt = pc_r + 10'h001;
                    if (op == OP_SLEEP)
                        state_nxt = ST_HALT;
                    else if (op == OP_SOFT_INTERRUPT)
                    begin
                        pc_nxt = INT_VECTOR;
                        state_nxt = ST_WAIT;
                    end
                    else if (op == OP_TABLE_READ)
                    begin
                        pc_nxt = pc_r;
                        state_nxt = ST_FLUSH;
                    end
                    else if (is_jump)
                    begin
                        pc_nxt = target;
                        state_nxt = ST_FLUSH;
                    end
                    else if (skip)
                        state_nxt = ST_FLUSH;
                end
                ST_WAIT: state_nxt = ST_FLUSH;
                ST_FLUSH:
                begin
                    ir_nxt = i_pm_data;
                    pc_nxt = pc_r + 10'h001;
                    state_nxt = ST_EXEC;
                end
                ST_HALT:
                begin
                    if (i_wake)
                        state_nxt = ST_EXEC;
                end
                default: state_nxt = ST_FLUSH;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_r <= ST_FLUSH;
            pc_r <= PC_RESET;
            ir_r <= INSTR_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            ir_r <= ir_nxt;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            accum_r <= ACCUM_RESET;
            z_r <= 1'b0;
            hc_r <= 1'b0;
            c_r <= 1'b0;
        end
        else
        begin
            if (wr_accum)
                accum_r <= res;
            if (exec && upd_z)
                z_r <= (res == 8'h00);
            if (exec && is_arith)
                hc_r <= sum.hc;
            if (exec && upd_c)
                c_r <= (op == OP_ROT_RIGHT) ? file_val[0] :
                       (op == OP_ROT_LEFT) ? file_val[7] : sum.c;
            else if (exec && op == OP_DECIMAL_ADJUST)
                c_r <= bcd_carry;
        end
    end

    // status bits; a same-cycle watchdog timeout wins
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            timeout_r <= 1'b1;
            powerdown_r <= 1'b1;
            irq_en_r <= 1'b0;
            wdt_clear_r <= 1'b0;
            sleep_r <= 1'b0;
        end
        else
        begin
            wdt_clear_r <= exec && (op == OP_WATCHDOG_CLEAR);
            sleep_r <= exec && (op == OP_SLEEP);
            if (exec && op == OP_SLEEP)
                powerdown_r <= 1'b0;
            else if (exec && op == OP_WATCHDOG_CLEAR)
                powerdown_r <= 1'b1;
            if (i_wdt_timeout)
                timeout_r <= 1'b0;
            else if (exec && (op == OP_SLEEP || op == OP_WATCHDOG_CLEAR))
                timeout_r <= 1'b1;
            if (exec && (op == OP_IRQ_ENABLE || op == OP_RETURN_IRQ_ENABLE))
                irq_en_r <= 1'b1;
            else if (exec && (op == OP_IRQ_DISABLE || op == OP_SOFT_INTERRUPT))
                irq_en_r <= 1'b0;
        end
    end

    // stack wraps; deep nesting overwrites the oldest entry
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            stk_idx_r <= 3'h0;
        else if (exec && (is_call || op == OP_SOFT_INTERRUPT))
        begin
            stack_r[stk_idx_r] <= pc_r;
            stk_idx_r <= stk_idx_r + 3'h1;
        end
        else if (exec && is_ret)
            stk_idx_r <= stk_top;
    end

    // write ports, one cycle late
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            file_wr_r <= '0;
            page_wr_r <= '0;
        end
        else
        begin
            file_wr_r <= '{we: wr_file, addr: file_addr, data: res};
            page_wr_r <= '{we: exec && page_store && store_ok, page: page_sel,
                           addr: page_addr, data: accum_r};
        end
    end

    // apb slave, one wait state; only the run bit is writable
    wire apb_access = i_psel && i_penable && !pready_r;
    wire addr_ok = (i_paddr == REG_CTRL) || (i_paddr == REG_STATUS) || (i_paddr == REG_ACCUM);
    wire [31:0] status_word = {6'h00, pc_r, 6'h00, state_r, 1'b0, irq_en_r,
                               (state_r == ST_HALT), timeout_r, powerdown_r, z_r, hc_r, c_r};
    wire [31:0] rd_word = (i_paddr == REG_CTRL) ? {31'h0000_0000, run_r} :
                          (i_paddr == REG_STATUS) ? status_word :
                          (i_paddr == REG_ACCUM) ? {24'h00_0000, accum_r} : 32'h0000_0000;

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            run_r <= CTRL_RUN_RESET;
        end
        else
        begin
            pready_r <= apb_access;
            pslverr_r <= apb_access && !addr_ok;
            prdata_r <= (apb_access && !i_pwrite) ? rd_word : 32'h0000_0000;
            if (apb_access && i_pwrite && i_paddr == REG_CTRL && i_pstrb[0])
                run_r <= i_pwdata[CTRL_RUN_POS];
        end
    end

    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_pm_addr = pc_r;
    assign o_file_raddr = ir_r[5:0];
    assign o_file_wr = file_wr_r;
    assign o_page_rsel = ir_r[5:PAGE_LSB];
    assign o_page_raddr = ir_r[3:0];
    assign o_page_wr = page_wr_r;
    assign o_wdt_clear = wdt_clear_r;
    assign o_sleep_req = sleep_r;
    assign o_timeout_flag = timeout_r;
    assign o_powerdown_flag = powerdown_r;
    assign o_irq_enable = irq_en_r;
endmodule // mie_core
`default_nettype wire

/* testbench/mie_core_properties.sv */
// Purpose: port checker for mie_core
// Assumes: one clock domain, synchronous reset
// Notes: cycles where a timeout beats a flag set are excluded
`timescale 1ns/10ps
`default_nettype none
module mie_core_chk
    import mie_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire mie_page_wr_type o_page_wr,
    input wire logic o_wdt_clear,
    input wire logic o_sleep_req,
    input wire logic i_wdt_timeout,
    input wire logic o_timeout_flag,
    input wire logic o_powerdown_flag
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_access;
        i_psel && i_penable && !o_pready;
    endsequence
    a_ready_one_cycle: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    a_one_wait_state: assert property (s_access |=> o_pready)
        else $error("ready not after one wait");
    a_error_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    a_io_store_floor: assert property (o_page_wr.we && o_page_wr.page == PAGE_IO
        |-> o_page_wr.addr >= IO_PAGE_MIN) else $error("io store below floor");
    a_sleep_sets_flags: assert property (o_sleep_req && !$past(i_wdt_timeout)
        |-> o_timeout_flag && !o_powerdown_flag) else $error("sleep flags wrong");
    a_clear_sets_flags: assert property (o_wdt_clear && !$past(i_wdt_timeout)
        |-> o_timeout_flag && o_powerdown_flag) else $error("clear flags wrong");
    a_timeout_wins: assert property (i_wdt_timeout |=> !o_timeout_flag)
        else $error("timeout flag kept");
    a_powerdown_by_sleep: assert property ($fell(o_powerdown_flag) |-> o_sleep_req)
        else $error("powerdown fell without sleep");
endmodule // mie_core_chk
bind mie_core mie_core_chk u_chk (.*);
`default_nettype wire

/* testbench/mie_mem_model.sv */
// Purpose: program, file and page memories
// Assumes: reads answer in the same cycle as the address
// Notes: empty words read as no-operation
`timescale 1ns/10ps
`default_nettype none
module mie_mem_model
    import mie_pkg::*;
(
    input wire logic i_clk,
    input wire logic [PC_W-1:0] i_pm_addr,
    output logic [15:0] o_pm_data,
    input wire logic [5:0] i_file_raddr,
    output logic [7:0] o_file_rdata,
    input wire mie_file_wr_type i_file_wr,
    input wire logic [1:0] i_page_rsel,
    input wire logic [3:0] i_page_raddr,
    output logic [7:0] o_page_rdata,
    input wire mie_page_wr_type i_page_wr
);
    logic [15:0] mem [1024];
    logic [7:0] file [64];
    logic [7:0] pg [4][16];
    initial foreach (mem[i]) mem[i] = INSTR_IDLE;
    assign o_pm_data = mem[i_pm_addr];
    assign o_file_rdata = file[i_file_raddr];
    assign o_page_rdata = pg[i_page_rsel][i_page_raddr];
    always @(posedge i_clk)
    begin
        if (i_file_wr.we)
            file[i_file_wr.addr] <= i_file_wr.data;
        if (i_page_wr.we)
            pg[i_page_wr.page][i_page_wr.addr] <= i_page_wr.data;
    end
endmodule // mie_mem_model
`default_nettype wire

/* testbench/mie_core_tb_top.sv */
// Purpose: self-checking bench for mie_core
// Assumes: programs load during reset
// Notes: programs end in a jump to self
`timescale 1ns/10ps
`default_nettype none
module mie_core_tb_top;
    import mie_pkg::*;
    logic i_clk = 0, i_srst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, er;
    logic i_wake = 0, i_wdt_timeout = 0, o_pready, o_pslverr, o_wdt_clear, o_sleep_req;
    logic o_timeout_flag, o_powerdown_flag, o_irq_enable;
    logic [11:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata, rd;
    logic [3:0] i_pstrb = 4'hf, o_page_raddr;
    logic [PC_W-1:0] o_pm_addr;
    logic [15:0] i_pm_data;
    logic [15:0] q[$];
    logic [5:0] o_file_raddr;
    logic [7:0] i_file_rdata, i_page_rdata;
    logic [1:0] o_page_rsel;
    mie_file_wr_type o_file_wr;
    mie_page_wr_type o_page_wr;
    int bad_count = 0, total_checks = 0;
    always #5 i_clk = ~i_clk;
    mie_core uut (.*);
    mie_mem_model mdl (.i_clk(i_clk), .i_pm_addr(o_pm_addr), .o_pm_data(i_pm_data),
        .i_file_raddr(o_file_raddr), .o_file_rdata(i_file_rdata), .i_file_wr(o_file_wr),
        .i_page_rsel(o_page_rsel), .i_page_raddr(o_page_raddr),
        .o_page_rdata(i_page_rdata), .i_page_wr(o_page_wr));
    function automatic logic [15:0] ins(input mie_op_type op, input logic [9:0] f);
        return {op, f};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        chk({24'h0, got}, {24'h0, exp});
    endtask
    // request held until ready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        i_psel <= 1;
        i_penable <= 0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1;
        n = 0;
        do @(posedge i_clk) n++; while (o_pready !== 1 && n < 20);
        if (o_pready !== 1) bad_count++;
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 0;
        i_penable <= 0;
    endtask
    task automatic run(input logic [9:0] fin);
        int n;
        i_srst <= 1;
        foreach (q[i]) mdl.mem[i] = q[i];
        repeat (6) @(posedge i_clk);
        i_srst <= 0;
        n = 0;
        do @(posedge i_clk) n++; while (o_pm_addr !== fin && n < 100);
        if (o_pm_addr !== fin) bad_count++;
    endtask
    task automatic sc_arith;
        q = '{ins(OP_LOAD_IMMEDIATE, 10'h09a), ins(OP_DECIMAL_ADJUST, 10'h000),
            ins(OP_STORE_ACCUM, 10'h03e), ins(OP_LOAD_IMMEDIATE, 10'h012),
            ins(OP_IMM_SUBTRACT_BORROW, 10'h034), ins(OP_REG_SUBTRACT_BORROW, 10'h205),
            ins(OP_STORE_ACCUM, 10'h03f), ins(OP_JUMP, 10'h007)};
        mdl.file[5] = 8'h50;
        mdl.file[62] = 8'hff;
        run(10'h007);
        apb(0, REG_ACCUM, 0);
        chk(rd, 32'h0000_0022);
        apb(0, REG_STATUS, 0);
        chk(rd & 32'h0000_0007, 32'h0000_0001);
        chk8(mdl.file[5], 8'h2e);
        chk8(mdl.file[62], 8'h00);
        chk8(mdl.file[63], 8'h22);
    endtask
    task automatic sc_skip;
        q = '{ins(OP_TEST_SKIP_IF_CLEAR, 10'h081), ins(OP_LOAD_IMMEDIATE, 10'h011),
            ins(OP_STORE_ACCUM, 10'h004), ins(OP_TEST_SKIP_IF_CLEAR, 10'h001),
            ins(OP_LOAD_IMMEDIATE, 10'h055), ins(OP_TEST_SKIP_IF_SET, 10'h081),
            ins(OP_LOAD_IMMEDIATE, 10'h022), ins(OP_INCREMENT_SKIP_ZERO, 10'h002),
            ins(OP_LOAD_IMMEDIATE, 10'h033), ins(OP_DECREMENT_SKIP_ZERO, 10'h203),
            ins(OP_LOAD_IMMEDIATE, 10'h044), ins(OP_JUMP, 10'h00b)};
        mdl.file[1] = 8'h04;
        mdl.file[2] = 8'hff;
        mdl.file[3] = 8'h01;
        run(10'h00b);
        apb(0, REG_ACCUM, 0);
        chk(rd, 32'h0000_0000);
        apb(0, REG_STATUS, 0);
        chk(rd & 32'h0000_0007, 32'h0000_0000);
        chk8(mdl.file[4], 8'h11);
        chk8(mdl.file[2], 8'hff);
        chk8(mdl.file[3], 8'h00);
    endtask
    task automatic sc_page;
        q = '{ins(OP_LOAD_IMMEDIATE, 10'h010), ins(OP_INDEXED_CALL, 10'h000),
            ins(OP_IO_PAGE_STORE, 10'h007), ins(OP_IO_PAGE_STORE, 10'h003),
            ins(OP_SPECIAL_PAGE_STORE, 10'h012), ins(OP_LOAD_IMMEDIATE, 10'h000),
            ins(OP_SPECIAL_PAGE_LOAD, 10'h019), ins(OP_STORE_ACCUM, 10'h006),
            ins(OP_IO_PAGE_LOAD, 10'h005), ins(OP_STORE_ACCUM, 10'h007),
            ins(OP_LOAD_IMMEDIATE, 10'h020), ins(OP_INDEXED_CALL, 10'h000),
            ins(OP_JUMP, 10'h00c)};
        mdl.mem[16] = ins(OP_LOAD_IMMEDIATE, 10'h03c);
        mdl.mem[17] = ins(OP_SUBROUTINE_RETURN, 10'h000);
        mdl.mem[32] = ins(OP_RETURN_WITH_LITERAL, 10'h047);
        mdl.pg[0][3] = 8'h99;
        mdl.pg[0][5] = 8'h5d;
        mdl.pg[1][9] = 8'h6b;
        run(10'h020);
        apb(0, REG_ACCUM, 0);
        chk(rd, 32'h0000_0047);
        chk8(mdl.pg[0][7], 8'h3c);
        chk8(mdl.pg[0][3], 8'h99);
        chk8(mdl.pg[1][2], 8'h3c);
        chk8(mdl.file[6], 8'h6b);
        chk8(mdl.file[7], 8'h5d);
    endtask
    task automatic sc_sleep;
        int n;
        q = '{ins(OP_LOAD_IMMEDIATE, 10'h003), ins(OP_INDEXED_JUMP, 10'h000),
            ins(OP_LOAD_IMMEDIATE, 10'h077), ins(OP_SLEEP, 10'h000),
            ins(OP_WATCHDOG_CLEAR, 10'h000), ins(OP_JUMP, 10'h005)};
        run(10'h003);
        n = 0;
        do @(posedge i_clk) n++; while (o_sleep_req !== 1 && n < 10);
        if (o_sleep_req !== 1) bad_count++;
        chk({30'h0, o_timeout_flag, o_powerdown_flag}, 32'h0000_0002);
        i_wdt_timeout <= 1;
        @(posedge i_clk);
        i_wdt_timeout <= 0;
        @(posedge i_clk);
        chk({31'h0, o_timeout_flag}, 32'h0000_0000);
        i_wake <= 1;
        n = 0;
        do @(posedge i_clk) n++; while (o_wdt_clear !== 1 && n < 10);
        if (o_wdt_clear !== 1) bad_count++;
        i_wake <= 0;
        chk({30'h0, o_timeout_flag, o_powerdown_flag}, 32'h0000_0003);
        apb(0, REG_ACCUM, 0);
        chk(rd, 32'h0000_0003);
    endtask
    // run is restored before returning
    task automatic sc_regs;
        apb(1, REG_CTRL, 32'h0000_0000);
        apb(0, REG_CTRL, 0);
        chk(rd, 32'h0000_0000);
        apb(0, 12'h00c, 0);
        chk({31'h0, er}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1, REG_CTRL, 32'h0000_0001);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        sc_arith;
        sc_skip;
        sc_page;
        sc_sleep;
        sc_regs;
        complete_run;
    end
    initial
    begin
        #100us;
        bad_count++;
        complete_run;
    end
endmodule // mie_core_tb_top
`default_nettype wire
